// ==== tec_pkg.sv ====
// Constants, register map, field layouts and types of the timer channel.
// Assumes AXI4-Lite access with 32-bit data and byte addresses.
// How it works
// RULE1: One 16-bit counter steps on the internal tap or external edges.
// RULE2: Software sees the count only through the counter read register.
// RULE3: Disabled counter holds ffff, yet its read register returns 0000.
// RULE4: Enable bit resets to 0; 0 stops and clears, 1 starts counting.
// RULE5: Writes to compare register a are copied into hidden buffer a.
// RULE6: Counter equal to hidden buffer a raises the match a request.
// RULE7: Writes to compare register b are copied into hidden buffer b.
// RULE8: Counter equal to hidden buffer b raises the match b request.
// RULE9: No bus address reaches either hidden compare buffer.
// RULE10: Reset clears both compare registers and both buffers to 0000.
// RULE11: Each input edge detector selects none, rising, falling or both.
// RULE12: Three select bits pick clock divided by 1 up to 128, or events; here all eight codes are taps and event_sel picks events.
// RULE13: First input serves as capture, event count and trigger input.
// RULE14: Output pins follow the settings of the output control register.
// RULE15: Control register zero is 8 bits, resets to 00, byte writable.
// RULE16: Rewriting control register zero unchanged has no side effect.
// RULE17: Without external trigger input, only software trigger starts pulses.
// RULE18: After enable, first count clock gives 0000; counter wraps past ffff.
package tec_pkg;
  // Bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int BYTE_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTL0 = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CCRA = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CCRB = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IOC0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EDGE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_OPT = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h20;
  // Control register zero layout
  localparam int CTL0_W = 8;
  localparam int CTL0_EN_BIT = 7;
  localparam int CKS_LSB = 0;
  localparam int CKS_W = 3;
  localparam logic [CTL0_W-1:0] CTL0_RST = 8'h00;
  localparam logic [CTL0_W-1:0] CTL0_WMASK = 8'h87;
  // Counter and compare values
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_STOP = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CCR_RST = 16'h0000;
  // Prescaler for the eight internal taps
  localparam int PRE_W = 7;
  localparam logic [PRE_W-1:0] PRE_ZERO = 7'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;
  localparam logic [PRE_W-1:0] PRE_ONES = 7'h7f;
  // Sticky event bits
  localparam int IRQ_W = 4;
  localparam int IRQ_MATCH_A = 0;
  localparam int IRQ_MATCH_B = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_CAPT = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  // Edge selection: two bits per input, input a in the low pair
  localparam int EDGE_N = 2;
  localparam int EDGE_MODE_W = 2;
  localparam int EDGE_W = 4;
  localparam logic [EDGE_W-1:0] EDGE_RST = 4'h0;
  typedef enum logic [EDGE_MODE_W-1:0]
  {
    TEC_EDGE_NONE,
    TEC_EDGE_RISE,
    TEC_EDGE_FALL,
    TEC_EDGE_BOTH
  } tec_edge_e;
  // Option register: software trigger bit always reads zero
  typedef struct packed {
    logic sw_trig;
    logic trig_en;
    logic capture_en;
    logic event_sel;
  } tec_opt_s;
  localparam int OPT_W = 4;
  localparam logic [OPT_W-1:0] OPT_RST = 4'h0;
  // Output control register
  typedef struct packed {
    logic b_level;
    logic b_en;
    logic a_level;
    logic a_en;
  } tec_ioc_s;
  localparam int IOC_W = 4;
  localparam logic [IOC_W-1:0] IOC_RST = 4'h0;
endpackage

// ==== tec_edge_det.sv ====
// Valid-edge detector for one timer input pin.
// Assumes the pin is already synchronous to aclk.
`timescale 1ns/1ps
module tec_edge_det
  import tec_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin and edge selection
  input wire logic pin,
  input wire tec_edge_e mode,
  // One-cycle valid edge
  output logic hit
);
  logic prev_q;
  logic hit_q;
  wire rise = pin & ~prev_q;
  wire fall = ~pin & prev_q;
  wire hit_d = ((mode == TEC_EDGE_RISE) & rise) | // RULE11
    ((mode == TEC_EDGE_FALL) & fall) |
    ((mode == TEC_EDGE_BOTH) & (rise | fall));
  assign hit = hit_q;

  // Previous level and registered edge pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_q <= 1'b0;
      hit_q <= 1'b0;
    end
    else
    begin
      prev_q <= pin;
      hit_q <= hit_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_EDGE_NONE: assert property ((mode == TEC_EDGE_NONE) |=> !hit_q) // RULE11
    else $error("edge reported with no edge selected");
  AST_EDGE_RISE: assert property // RULE11
    ((mode == TEC_EDGE_RISE) && $rose(pin) |=> hit_q)
    else $error("rising edge missed");
endmodule

// ==== tec_timer.sv ====
// One channel of a 16-bit timer/event counter with two compare buffers.
// Assumes an AXI4-Lite master and timer inputs synchronous to aclk.
`timescale 1ns/1ps
module tec_timer
  import tec_pkg::*;
#(
  parameter bit HAS_EXT_TRIG = 1'b1
)
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Timer pins
  input wire logic input_a_ch0,
  input wire logic input_b_ch0,
  output logic output_a_ch0,
  output logic output_b_ch0,
  // Interrupt requests
  output logic match_irq_a,
  output logic match_irq_b,
  output logic irq
);
  // Word index compare, used by both read and write decode
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] ofs);
    is_reg = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
    input logic [DATA_W-1:0] d, input logic [STRB_W-1:0] s);
    logic [CNT_W-1:0] r;
    r = old;
    for (int i = 0; i < CNT_W / BYTE_W; i++)
    begin
      if (s[i])
        r[i*BYTE_W +: BYTE_W] = d[i*BYTE_W +: BYTE_W];
    end
    merge16 = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic aw_full_q, w_full_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q;
  logic [STRB_W-1:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic [CTL0_W-1:0] ctl0_q;
  logic [CNT_W-1:0] ccr_a_q, ccr_b_q, buf_a_q, buf_b_q, cnt_q;
  logic ldbuf_a_q, ldbuf_b_q, started_q, sw_trig_q;
  logic [PRE_W-1:0] pre_q;
  tec_opt_s opt_q;
  tec_ioc_s ioc_q;
  logic [EDGE_W-1:0] edge_q;
  logic [IRQ_W-1:0] stat_q, mask_q;
  logic irq_q, match_a_q, match_b_q, out_a_q, out_b_q;
  logic [1:0] tog_q;
  logic [EDGE_N-1:0] hit;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken independently, then one response
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  assign s_axi_awready = ~aw_full_q & ~bvalid_q;
  assign s_axi_wready = ~w_full_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Write decode; the hidden buffers have no address at all
  wire wr_ctl0 = do_wr & is_reg(awaddr_q, OFS_CTL0) & wstrb_q[0];
  wire wr_ccra = do_wr & is_reg(awaddr_q, OFS_CCRA); // RULE9
  wire wr_ccrb = do_wr & is_reg(awaddr_q, OFS_CCRB); // RULE9
  wire wr_ioc = do_wr & is_reg(awaddr_q, OFS_IOC0) & wstrb_q[0];
  wire wr_edge = do_wr & is_reg(awaddr_q, OFS_EDGE) & wstrb_q[0];
  wire wr_opt = do_wr & is_reg(awaddr_q, OFS_OPT) & wstrb_q[0];
  wire wr_mask = do_wr & is_reg(awaddr_q, OFS_MASK) & wstrb_q[0];
  wire wr_hit = is_reg(awaddr_q, OFS_CTL0) | is_reg(awaddr_q, OFS_CCRA) |
    is_reg(awaddr_q, OFS_CCRB) | is_reg(awaddr_q, OFS_CNT) |
    is_reg(awaddr_q, OFS_IOC0) | is_reg(awaddr_q, OFS_EDGE) |
    is_reg(awaddr_q, OFS_OPT) | is_reg(awaddr_q, OFS_STAT) |
    is_reg(awaddr_q, OFS_MASK);
  wire [CNT_W-1:0] ccra_wval = merge16(ccr_a_q, wdata_q, wstrb_q);
  wire [CNT_W-1:0] ccrb_wval = merge16(ccr_b_q, wdata_q, wstrb_q);

  // Write holding registers and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (aw_fire)
        awaddr_q <= s_axi_awaddr;
      if (w_fire)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_full_q <= aw_fire | (aw_full_q & ~do_wr);
      w_full_q <= w_fire | (w_full_q & ~do_wr);
      if (do_wr)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data registered at the address handshake
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  wire en = ctl0_q[CTL0_EN_BIT];
  wire rd_ctl0 = is_reg(s_axi_araddr, OFS_CTL0);
  wire rd_ccra = is_reg(s_axi_araddr, OFS_CCRA);
  wire rd_ccrb = is_reg(s_axi_araddr, OFS_CCRB);
  wire rd_cnt = is_reg(s_axi_araddr, OFS_CNT);
  wire rd_ioc = is_reg(s_axi_araddr, OFS_IOC0);
  wire rd_edge = is_reg(s_axi_araddr, OFS_EDGE);
  wire rd_opt = is_reg(s_axi_araddr, OFS_OPT);
  wire rd_stat = is_reg(s_axi_araddr, OFS_STAT);
  wire rd_mask = is_reg(s_axi_araddr, OFS_MASK);
  wire rd_hit = rd_ctl0 | rd_ccra | rd_ccrb | rd_cnt | rd_ioc | rd_edge |
    rd_opt | rd_stat | rd_mask;
  // Stopped counter reads as zero even though it holds all ones
  wire [CNT_W-1:0] cnt_view = en ? cnt_q : CNT_ZERO; // RULE2 RULE3
  wire [CNT_W-1:0] rd_val =
    rd_ctl0 ? CNT_W'(ctl0_q) :
    rd_ccra ? ccr_a_q :
    rd_ccrb ? ccr_b_q :
    rd_cnt ? cnt_view :
    rd_ioc ? CNT_W'(ioc_q) :
    rd_edge ? CNT_W'(edge_q) :
    rd_opt ? CNT_W'(opt_q) :
    rd_stat ? CNT_W'(stat_q) :
    rd_mask ? CNT_W'(mask_q) : CNT_ZERO;
  wire stat_rd_clr = ar_fire & rd_stat;

  // Read data and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (ar_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= DATA_W'(rd_val);
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detectors, one per input pin
  wire [EDGE_N-1:0] pins = {input_b_ch0, input_a_ch0};
  genvar gi;
  generate
    for (gi = 0; gi < EDGE_N; gi++)
    begin : g_edge
      tec_edge_det u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pins[gi]),
        .mode(tec_edge_e'(edge_q[gi*EDGE_MODE_W +: EDGE_MODE_W])),
        .hit(hit[gi])
      );
    end
  endgenerate

  // Count clock: tap k fires when the low k prescaler bits are all ones
  wire [CKS_W-1:0] cks = ctl0_q[CKS_LSB +: CKS_W];
  wire tick_int = &(pre_q | (PRE_ONES << cks)); // RULE12
  wire tick = opt_q.event_sel ? hit[0] : tick_int; // RULE1 RULE13
  // External trigger only where the channel has the pin
  wire ext_trig = HAS_EXT_TRIG & opt_q.trig_en & hit[0]; // RULE13 RULE17
  wire trig_fire = en & (sw_trig_q | ext_trig); // RULE17
  wire count_step = en & tick & ~trig_fire;
  wire [CNT_W-1:0] cnt_nxt = cnt_q + CNT_ONE; // RULE18
  wire cap_a = en & opt_q.capture_en & hit[0]; // RULE13
  wire cap_b = en & opt_q.capture_en & hit[1];
  wire cmp_on = count_step & ~opt_q.capture_en;
  wire match_a_d = cmp_on & (cnt_nxt == buf_a_q); // RULE6
  wire match_b_d = cmp_on & (cnt_nxt == buf_b_q); // RULE8
  // First step out of the stopped value is not an overflow
  wire ovf_d = count_step & started_q & (cnt_q == CNT_STOP);
  wire [IRQ_W-1:0] ev_set = {cap_a | cap_b, ovf_d, match_b_d, match_a_d};

  // Counter and prescaler; disable clears both like a reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !en) // RULE3 RULE4
    begin
      cnt_q <= CNT_STOP;
      pre_q <= PRE_ZERO;
      started_q <= 1'b0;
    end
    else if (trig_fire)
    begin
      cnt_q <= CNT_ZERO;
      pre_q <= PRE_ZERO;
      started_q <= 1'b1;
    end
    else
    begin
      pre_q <= pre_q + PRE_ONE;
      if (count_step) // RULE1 RULE18
      begin
        cnt_q <= cnt_nxt;
        started_q <= 1'b1;
      end
    end
  end

  // Control registers; same-value rewrite changes nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl0_q <= CTL0_RST; // RULE4 RULE15
      ioc_q <= IOC_RST;
      edge_q <= EDGE_RST;
      opt_q <= OPT_RST;
      mask_q <= IRQ_RST;
      sw_trig_q <= 1'b0;
    end
    else
    begin
      if (wr_ctl0)
        ctl0_q <= wdata_q[CTL0_W-1:0] & CTL0_WMASK; // RULE15 RULE16
      if (wr_ioc)
        ioc_q <= wdata_q[IOC_W-1:0];
      if (wr_edge)
        edge_q <= wdata_q[EDGE_W-1:0];
      if (wr_opt)
        opt_q <= {1'b0, wdata_q[OPT_W-2:0]};
      if (wr_mask)
        mask_q <= wdata_q[IRQ_W-1:0];
      sw_trig_q <= wr_opt & wdata_q[OPT_W-1];
    end
  end

  // Compare registers and their hidden buffers; capture beats a write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ccr_a_q <= CCR_RST; // RULE10
      ccr_b_q <= CCR_RST;
      buf_a_q <= CCR_RST;
      buf_b_q <= CCR_RST;
      ldbuf_a_q <= 1'b0;
      ldbuf_b_q <= 1'b0;
    end
    else
    begin
      if (cap_a)
        ccr_a_q <= cnt_q;
      else if (wr_ccra)
        ccr_a_q <= ccra_wval;
      if (cap_b)
        ccr_b_q <= cnt_q;
      else if (wr_ccrb)
        ccr_b_q <= ccrb_wval;
      ldbuf_a_q <= wr_ccra & ~opt_q.capture_en & ~cap_a;
      ldbuf_b_q <= wr_ccrb & ~opt_q.capture_en & ~cap_b;
      if (ldbuf_a_q)
        buf_a_q <= ccr_a_q; // RULE5
      if (ldbuf_b_q)
        buf_b_q <= ccr_b_q; // RULE7
    end
  end

  // Status, interrupts and output pins; a new event wins over a read clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= IRQ_RST;
      irq_q <= 1'b0;
      match_a_q <= 1'b0;
      match_b_q <= 1'b0;
      tog_q <= 2'h0;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~{IRQ_W{stat_rd_clr}}) | ev_set;
      irq_q <= |(stat_q & mask_q);
      match_a_q <= match_a_d; // RULE6
      match_b_q <= match_b_d; // RULE8
      tog_q <= en ? (tog_q ^ {match_b_d, match_a_d}) : 2'h0;
      out_a_q <= ioc_q.a_en & (ioc_q.a_level ^ tog_q[0]); // RULE14
      out_b_q <= ioc_q.b_en & (ioc_q.b_level ^ tog_q[1]); // RULE14
    end
  end
  assign irq = irq_q;
  assign match_irq_a = match_a_q;
  assign match_irq_b = match_b_q;
  assign output_a_ch0 = out_a_q;
  assign output_b_ch0 = out_b_q;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ccra_written;
    wr_ccra && !opt_q.capture_en && !cap_a ##1 ldbuf_a_q;
  endsequence
  sequence s_first_step;
    en && !started_q && count_step;
  endsequence
  AST_STOP_HOLD: assert property (!en |=> cnt_q == CNT_STOP) // RULE3
    else $error("stopped counter does not hold all ones");
  AST_READ_ZERO: assert property // RULE3
    (ar_fire && rd_cnt && !en |=> s_axi_rdata == '0)
    else $error("stopped counter read is not zero");
  AST_MATCH_A: assert property // RULE6
    (match_irq_a |-> cnt_q == $past(buf_a_q))
    else $error("match a without equal count");
  AST_MATCH_B: assert property // RULE8
    (cmp_on && cnt_nxt == buf_b_q |=> match_irq_b)
    else $error("match b request missed");
  AST_BUF_COPY: assert property // RULE5
    (s_ccra_written |=> buf_a_q == $past(ccr_a_q))
    else $error("compare value not copied to buffer a");
  AST_FIRST_ZERO: assert property (s_first_step |=> cnt_q == CNT_ZERO) // RULE18
    else $error("first count after enable is not zero");
  AST_CTL0_RSVD: assert property (ctl0_q[6:3] == 4'h0) // RULE15
    else $error("reserved control bits set");
  AST_DIV128: assert property // RULE12
    (en && !opt_q.event_sel && cks == 3'h7 && tick_int
      |=> !tick_int [*8])
    else $error("divide by 128 tap fires too early");
  AST_SW_ONLY: assert property // RULE17
    (trig_fire && !sw_trig_q |-> HAS_EXT_TRIG && opt_q.trig_en)
    else $error("trigger started without software");
  AST_IRQ_LVL: assert property ((stat_q & mask_q) != '0 |=> irq) // RULE6 RULE8
    else $error("unmasked status without interrupt");
endmodule

// ==== timer_event_counter16_tb_top.sv ====
// Self-checking bench for the timer channel, bus-driven over AXI4-Lite.
// Assumes the tec_pkg register map and the hand-over timing of tec_timer.
`timescale 1ns/1ps
module timer_event_counter16_tb_top
  import tec_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////
  // Stimulus and observation signals
  logic aclk, aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [STRB_W-1:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic in_a, in_b, out_a, out_b, irq_a, irq_b, irq;
  int num_errors, checked, k, n, m, t, e, md, ev;
  logic [ADDR_W-1:0] ofs [6] = '{OFS_CTL0, OFS_CCRA, OFS_CCRB, OFS_CNT,
    OFS_STAT, OFS_MASK};

  ////////////////////////////////////////////////////////////////////////
  // Device under test
  tec_timer i_tec_timer (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .input_a_ch0(in_a), .input_b_ch0(in_b),
    .output_a_ch0(out_a), .output_b_ch0(out_b), .match_irq_a(irq_a),
    .match_irq_b(irq_b), .irq(irq)
  );

  // Free-running 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared compare, bus tasks and closing
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] sn);
    checked++;
    if (sn !== ex)
    begin
      $display("unexpected %s expected %h seen %h", nm, ex, sn);
      num_errors++;
    end
  endtask

  // Write; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int w;
    w = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      w++;
    end
    while (!bvalid && w < 300);
    bready <= 1'b0;
    if (w >= 300) num_errors++;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
    // Extra edge so the next request never lands in this time step
    @(posedge aclk);
  endtask

  // Read and compare data and response
  task automatic rc(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] er);
    int w;
    w = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      w++;
    end
    while (!rvalid && w < 300);
    rready <= 1'b0;
    if (w >= 300) num_errors++;
    chk("rdata", ex, rdata);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, well beyond the roughly 5k cycles the tests need
  initial
  begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready, in_a, in_b} = '0;
    void'($urandom(32'h049f0e18));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values and read-back of control register zero
    foreach (ofs[i]) rc(ofs[i], 32'h0, RESP_OKAY);
    wr(OFS_CTL0, 32'hff, RESP_OKAY);
    rc(OFS_CTL0, 32'h87, RESP_OKAY);
    wr(OFS_CTL0, 32'h0, RESP_OKAY);
    rc(OFS_CNT, 32'h0, RESP_OKAY);
    // Addresses outside the map, hidden buffers included, answer SLVERR
    rc(8'h24, 32'h0, RESP_SLVERR);
    wr(8'h24, 32'h1234, RESP_SLVERR);
    // Output controller levels while stopped
    wr(OFS_IOC0, 32'h3, RESP_OKAY);
    chk("out_a", 32'h1, {31'h0, out_a});
    chk("out_b", 32'h0, {31'h0, out_b});
    wr(OFS_IOC0, 32'hc, RESP_OKAY);
    chk("out_a", 32'h0, {31'h0, out_a});
    chk("out_b", 32'h1, {31'h0, out_b});
    wr(OFS_IOC0, 32'h0, RESP_OKAY);
    // Both compare channels under every internal tap
    for (k = 0; k < 8; k++)
    begin
      n = $urandom_range(15, 8);
      m = $urandom_range(4, 1);
      wr(OFS_CCRA, 32'(n), RESP_OKAY);
      wr(OFS_CCRB, 32'(n + m), RESP_OKAY);
      rc(OFS_CCRA, 32'(n), RESP_OKAY);
      wr(OFS_CTL0, 32'h80 | 32'(k), RESP_OKAY);
      t = 0;
      while (irq_a !== 1'b1 && t < 4000)
      begin
        @(posedge aclk);
        t++;
      end
      // Match a shows in the same cycle as the step onto buffer a
      e = ((n + 1) << k) - 1;
      chk("match_a_cycle", 32'(e), 32'(t));
      t = 0;
      do
      begin
        @(posedge aclk);
        t++;
      end
      while (irq_b !== 1'b1 && t < 4000);
      chk("match_b_gap", 32'(m << k), 32'(t));
      if (k == 0)
      begin
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(OFS_MASK, 32'h3, RESP_OKAY);
        chk("irq_unmasked", 32'h1, {31'h0, irq});
        rc(OFS_STAT, 32'h3, RESP_OKAY);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        wr(OFS_MASK, 32'h0, RESP_OKAY);
      end
      // Slow taps leave time to read the count and rewrite the control
      if (k >= 5)
      begin
        rc(OFS_CNT, 32'(n + m), RESP_OKAY);
        wr(OFS_CTL0, 32'h80 | 32'(k), RESP_OKAY);
        rc(OFS_CNT, 32'(n + m), RESP_OKAY);
      end
      wr(OFS_CTL0, 32'h0, RESP_OKAY);
      rc(OFS_CNT, 32'h0, RESP_OKAY);
    end
    // Event counting on input a under each edge selection
    wr(OFS_OPT, 32'h1, RESP_OKAY);
    for (md = 0; md < 4; md++)
    begin
      wr(OFS_EDGE, 32'(md | (md << 2)), RESP_OKAY);
      wr(OFS_CTL0, 32'h80, RESP_OKAY);
      repeat (4)
      begin
        in_a <= 1'b1;
        in_b <= 1'($urandom);
        repeat (3) @(posedge aclk);
        in_a <= 1'b0;
        repeat (3) @(posedge aclk);
      end
      ev = (md == 3) ? 8 : ((md == 0) ? 0 : 4);
      rc(OFS_CNT, (ev == 0) ? 32'hffff : 32'(ev - 1), RESP_OKAY);
      wr(OFS_CTL0, 32'h0, RESP_OKAY);
    end
    // Software then external trigger restart the slow count at zero
    wr(OFS_EDGE, 32'h1, RESP_OKAY);
    wr(OFS_OPT, 32'h4, RESP_OKAY);
    wr(OFS_CTL0, 32'h87, RESP_OKAY);
    wr(OFS_OPT, 32'hc, RESP_OKAY);
    rc(OFS_OPT, 32'h4, RESP_OKAY);
    rc(OFS_CNT, 32'h0, RESP_OKAY);
    repeat (200) @(posedge aclk);
    rc(OFS_CNT, 32'h1, RESP_OKAY);
    in_a <= 1'b1;
    repeat (3) @(posedge aclk);
    in_a <= 1'b0;
    rc(OFS_CNT, 32'h0, RESP_OKAY);
    wr(OFS_CTL0, 32'h0, RESP_OKAY);
    // Capture of the running count by input a, sticky capture bit
    wr(OFS_OPT, 32'h2, RESP_OKAY);
    wr(OFS_CTL0, 32'h80, RESP_OKAY);
    in_a <= 1'b1;
    repeat (3) @(posedge aclk);
    in_a <= 1'b0;
    rc(OFS_CCRA, 32'h2, RESP_OKAY);
    rc(OFS_STAT, 32'hb, RESP_OKAY);
    wr(OFS_CTL0, 32'h0, RESP_OKAY);
    report_and_stop;
  end
endmodule
